// [dtec_defs.svh]
/*
  Register offsets, field positions, reset values and clock codes of the
  dual 8-bit timer/event counter.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef DTEC_DEFS_SVH
`define DTEC_DEFS_SVH

// Byte addresses on the register bus
`define DTEC_ADDR_CLK_SEL 8'h00
`define DTEC_ADDR_OUT_CTRL 8'h04
`define DTEC_ADDR_OSC_MODE 8'h08
`define DTEC_ADDR_CMP_ONE 8'h0c
`define DTEC_ADDR_CMP_TWO 8'h10
`define DTEC_ADDR_CNT_ONE 8'h14
`define DTEC_ADDR_CNT_TWO 8'h18
`define DTEC_ADDR_STATUS 8'h1c
`define DTEC_ADDR_MASK 8'h20

// Field positions inside the output control register, per channel; clock select field width; oscillation mode bit
`define DTEC_OCTL_ENABLE 0
`define DTEC_OCTL_LEVEL_SET 2
`define DTEC_OCTL_LEVEL_CLR 3
`define DTEC_CH_STRIDE 4
`define DTEC_CLK_FIELD_W 4
`define DTEC_OSC_HALVE_BIT 0

// Reset values
`define DTEC_RST_BYTE 8'h00
`define DTEC_RST_CH 2'h0

// Count clock codes
`define DTEC_CODE_EDGE_FALL 4'h0
`define DTEC_CODE_EDGE_RISE 4'h1
`define DTEC_CODE_INT_FIRST 4'h6
`define DTEC_CODE_INT_LAST 4'hf
`define DTEC_CODE_INT_BIAS 4'h5
`define DTEC_SHIFT_LAST 4'hb

// Oscillator period in ns; the prescaler runs at the bus clock rate
`define DTEC_FX_PERIOD_NS 20
`define DTEC_PRESCALE_W 13

`endif

// [dtec_pkg.sv]
/*
  Types shared by the timer/event counter modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dtec_pkg;
  typedef logic [7:0] dtec_byte_t;
  typedef enum logic [1:0] {
    DTEC_RESP_OKAY = 2'h0,
    DTEC_RESP_SLVERR = 2'h2
  } dtec_resp_t;
endpackage

// [dtec_channel.sv]
/*
  One 8-bit timer/event counter channel: count clock selection, counter,
  compare match and square-wave output flip-flop.
  Assumes the event input is synchronous to aclk and the shared prescaler
  is a free-running count at the oscillator rate.
*/
`timescale 1ns/100ps
`include "dtec_defs.svh"

module dtec_channel
  import dtec_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] clock_code,
  input wire logic halve,
  input wire logic [`DTEC_PRESCALE_W-1:0] prescale,
  input wire logic event_input,
  input wire dtec_byte_t compare,
  input wire logic out_enable,
  input wire logic level_set,
  input wire logic level_reset,
  output dtec_byte_t count,
  output logic match,
  output logic wave
);
  dtec_byte_t count_reg;
  dtec_byte_t count_next;
  logic match_reg;
  logic match_next;
  logic wave_reg;
  logic wave_next;
  logic ev_prev_reg;
  logic [3:0] shift;
  logic internal;
  logic [`DTEC_PRESCALE_W-1:0] mask;
  logic tick;

  always_comb begin
    shift = 4'h0;
    internal = 1'b0;
    if (clock_code >= `DTEC_CODE_INT_FIRST) begin
      internal = 1'b1;
      shift = (clock_code == `DTEC_CODE_INT_LAST) ? `DTEC_SHIFT_LAST :
        clock_code - `DTEC_CODE_INT_BIAS;
      if (!halve) begin
        shift = shift + 4'h1;
      end
    end
    mask = (`DTEC_PRESCALE_W'(1) << shift) - `DTEC_PRESCALE_W'(1);
    case (clock_code)
      `DTEC_CODE_EDGE_FALL: tick = ev_prev_reg & ~event_input;
      `DTEC_CODE_EDGE_RISE: tick = ~ev_prev_reg & event_input;
      // Prohibited codes leave internal low, so the counter simply holds
      default: tick = internal && ((prescale & mask) == mask);
    endcase
  end

  always_comb begin
    count_next = count_reg;
    match_next = 1'b0;
    wave_next = wave_reg;
    if (tick) begin
      if (count_reg == compare) begin
        count_next = 8'h00;
        match_next = 1'b1;
      end else begin
        count_next = count_reg + 8'h01;
      end
    end
    if (match_next && out_enable) begin
      wave_next = ~wave_reg;
    end
    // Software preset wins over a toggle in the same cycle
    if (level_set) begin
      wave_next = 1'b1;
    end else if (level_reset) begin
      wave_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 8'h00;
      match_reg <= 1'b0;
      wave_reg <= 1'b0;
      ev_prev_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      match_reg <= match_next;
      wave_reg <= wave_next;
      ev_prev_reg <= event_input;
    end
  end

  assign count = count_reg;
  assign match = match_reg;
  assign wave = wave_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  match_clears_a: assert property (
    tick && count_reg == compare |=> match_reg && count_reg == 8'h00)
    else $error("match did not clear the counter");
  count_step_a: assert property (
    tick && count_reg != compare |=> !match_reg && count_reg == $past(count_reg) + 8'h01)
    else $error("counter did not advance on a count tick");
  wave_toggle_a: assert property (
    match_next && out_enable && !level_set && !level_reset |=> wave_reg != $past(wave_reg))
    else $error("wave output did not invert on match");
  wave_hold_a: assert property (
    !out_enable && !level_set && !level_reset |=> $stable(wave_reg))
    else $error("wave output moved while disabled");
  level_preset_a: assert property (
    level_set |=> wave_reg)
    else $error("level set did not raise the wave output");
  wrong_edge_a: assert property (
    clock_code == `DTEC_CODE_EDGE_RISE && ev_prev_reg && !event_input |=> $stable(count_reg))
    else $error("counted on the falling edge while rising selected");
  prescale_gap_a: assert property (
    clock_code == `DTEC_CODE_INT_FIRST && !halve && prescale[1:0] != 2'h3 |=> $stable(count_reg))
    else $error("count tick off the prescaled period");

  match_seen_c: cover property (match_reg && out_enable);
  edge_count_c: cover property (clock_code == `DTEC_CODE_EDGE_FALL && tick);
  slow_code_c: cover property (clock_code == `DTEC_CODE_INT_LAST && tick);
endmodule

// [dtec_top.sv]
/*
  Dual 8-bit timer/event counter with an AXI4-Lite register slave,
  sticky match status, interrupt mask and square-wave outputs.
  Assumes event inputs are synchronous to aclk; aclk is the oscillator.
*/
`timescale 1ns/100ps
`include "dtec_defs.svh"

module dtec_top
  import dtec_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chan_one_event_input,
  input wire logic chan_two_event_input,
  output logic chan_one_wave_output,
  output logic chan_two_wave_output,
  output logic chan_one_match_irq,
  output logic chan_two_match_irq,
  output logic irq
);
  // Bus handshake state
  logic aw_got_reg, aw_got_next;
  logic w_got_reg, w_got_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] wr_data_reg, wr_data_next;
  logic wr_strb0_reg, wr_strb0_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  dtec_resp_t bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  dtec_resp_t rresp_reg, rresp_next;
  logic do_write;

  // Register file state
  dtec_byte_t timer_clock_select_reg, timer_clock_select_next;
  logic [1:0] out_enable_reg, out_enable_next;
  logic oscillation_mode_reg, oscillation_mode_next;
  dtec_byte_t compare_reg [2];
  dtec_byte_t compare_next [2];
  logic [1:0] status_reg, status_next;
  logic [1:0] mask_reg, mask_next;
  logic [1:0] level_set_reg, level_set_next;
  logic [1:0] level_reset_reg, level_reset_next;
  logic irq_reg;
  logic [1:0] status_clear;

  logic [`DTEC_PRESCALE_W-1:0] prescale_reg;
  dtec_byte_t count [2];
  logic [1:0] match;
  logic [1:0] wave;
  logic [1:0] event_pins;

  function automatic logic addr_known(input logic [7:0] addr);
    case (addr)
      `DTEC_ADDR_CLK_SEL, `DTEC_ADDR_OUT_CTRL, `DTEC_ADDR_OSC_MODE,
      `DTEC_ADDR_CMP_ONE, `DTEC_ADDR_CMP_TWO, `DTEC_ADDR_CNT_ONE,
      `DTEC_ADDR_CNT_TWO, `DTEC_ADDR_STATUS, `DTEC_ADDR_MASK: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  // Write and read channels of the bus slave
  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    wr_strb0_next = wr_strb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_got_next = 1'b1;
      wr_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_got_next = 1'b1;
      wr_data_next = s_axi_wdata;
      wr_strb0_next = s_axi_wstrb[0];
    end
    do_write = aw_got_reg && w_got_reg && !bvalid_reg;
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (do_write) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = addr_known(wr_addr_reg) ? DTEC_RESP_OKAY : DTEC_RESP_SLVERR;
    end
    awready_next = !aw_got_next && !bvalid_next;
    wready_next = !w_got_next && !bvalid_next;

    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = addr_known(s_axi_araddr) ? DTEC_RESP_OKAY : DTEC_RESP_SLVERR;
      // Set and reset strobe bits always read back as zero
      case (s_axi_araddr)
        `DTEC_ADDR_CLK_SEL: rdata_next = {24'h000000, timer_clock_select_reg};
        `DTEC_ADDR_OUT_CTRL: rdata_next = {27'h0000000, out_enable_reg[1], 3'h0,
          out_enable_reg[0]};
        `DTEC_ADDR_OSC_MODE: rdata_next = {31'h00000000, oscillation_mode_reg};
        `DTEC_ADDR_CMP_ONE: rdata_next = {24'h000000, compare_reg[0]};
        `DTEC_ADDR_CMP_TWO: rdata_next = {24'h000000, compare_reg[1]};
        `DTEC_ADDR_CNT_ONE: rdata_next = {24'h000000, count[0]};
        `DTEC_ADDR_CNT_TWO: rdata_next = {24'h000000, count[1]};
        `DTEC_ADDR_STATUS: rdata_next = {30'h00000000, status_reg};
        `DTEC_ADDR_MASK: rdata_next = {30'h00000000, mask_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 32'h00000000;
      wr_strb0_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= DTEC_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= DTEC_RESP_OKAY;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      wr_strb0_reg <= wr_strb0_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Register file; no register is wider than one byte, so only lane 0 writes
  always_comb begin
    timer_clock_select_next = timer_clock_select_reg;
    out_enable_next = out_enable_reg;
    oscillation_mode_next = oscillation_mode_reg;
    compare_next = compare_reg;
    mask_next = mask_reg;
    level_set_next = `DTEC_RST_CH;
    level_reset_next = `DTEC_RST_CH;
    status_clear = 2'h0;
    if (do_write && wr_strb0_reg) begin
      case (wr_addr_reg)
        `DTEC_ADDR_CLK_SEL: timer_clock_select_next = wr_data_reg[7:0];
        `DTEC_ADDR_OUT_CTRL: begin
          for (int i = 0; i < 2; i++) begin
            out_enable_next[i] = wr_data_reg[i*`DTEC_CH_STRIDE + `DTEC_OCTL_ENABLE];
            level_set_next[i] = wr_data_reg[i*`DTEC_CH_STRIDE + `DTEC_OCTL_LEVEL_SET];
            level_reset_next[i] = wr_data_reg[i*`DTEC_CH_STRIDE + `DTEC_OCTL_LEVEL_CLR];
          end
        end
        `DTEC_ADDR_OSC_MODE: oscillation_mode_next = wr_data_reg[`DTEC_OSC_HALVE_BIT];
        `DTEC_ADDR_CMP_ONE: compare_next[0] = wr_data_reg[7:0];
        `DTEC_ADDR_CMP_TWO: compare_next[1] = wr_data_reg[7:0];
        `DTEC_ADDR_STATUS: status_clear = wr_data_reg[1:0];
        `DTEC_ADDR_MASK: mask_next = wr_data_reg[1:0];
        default: status_clear = 2'h0;
      endcase
    end
    // A match in the clearing cycle survives the clear
    status_next = (status_reg & ~status_clear) | match;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_clock_select_reg <= `DTEC_RST_BYTE;
      out_enable_reg <= `DTEC_RST_CH;
      oscillation_mode_reg <= 1'b0;
      compare_reg <= '{`DTEC_RST_BYTE, `DTEC_RST_BYTE};
      status_reg <= `DTEC_RST_CH;
      mask_reg <= `DTEC_RST_CH;
      level_set_reg <= `DTEC_RST_CH;
      level_reset_reg <= `DTEC_RST_CH;
      irq_reg <= 1'b0;
      prescale_reg <= '0;
    end else begin
      timer_clock_select_reg <= timer_clock_select_next;
      out_enable_reg <= out_enable_next;
      oscillation_mode_reg <= oscillation_mode_next;
      compare_reg <= compare_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      level_set_reg <= level_set_next;
      level_reset_reg <= level_reset_next;
      irq_reg <= |(status_reg & mask_reg);
      prescale_reg <= prescale_reg + `DTEC_PRESCALE_W'(1);
    end
  end

  assign event_pins = {chan_two_event_input, chan_one_event_input};

  // One shared prescaler keeps both channels phase-aligned at equal codes
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    dtec_channel u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .clock_code(timer_clock_select_reg[ch*`DTEC_CLK_FIELD_W +: `DTEC_CLK_FIELD_W]),
      .halve(oscillation_mode_reg),
      .prescale(prescale_reg),
      .event_input(event_pins[ch]),
      .compare(compare_reg[ch]),
      .out_enable(out_enable_reg[ch]),
      .level_set(level_set_reg[ch]),
      .level_reset(level_reset_reg[ch]),
      .count(count[ch]),
      .match(match[ch]),
      .wave(wave[ch])
    );
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign chan_one_wave_output = wave[0];
  assign chan_two_wave_output = wave[1];
  assign chan_one_match_irq = match[0];
  assign chan_two_match_irq = match[1];
  assign irq = irq_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  irq_level_a: assert property (
    (status_reg & mask_reg) != 2'h0 |=> irq_reg)
    else $error("unmasked status did not raise interrupt");
  status_sticky_a: assert property (
    match[1] |=> status_reg[1])
    else $error("channel two match not recorded");
  write_answer_a: assert property (
    aw_got_reg && w_got_reg && !bvalid_reg |=> bvalid_reg [*1] ##0 !awready_reg)
    else $error("write not answered one cycle after both halves");
  field_two_a: assert property (
    do_write && wr_strb0_reg && wr_addr_reg == `DTEC_ADDR_CLK_SEL
    |=> g_chan[1].u_chan.clock_code == $past(wr_data_reg[7:4]))
    else $error("channel two clock code not taken from bits 7:4");
  status_one_a: assert property (
    match[0] |=> status_reg[0])
    else $error("channel one match not recorded");
  irq_quiet_a: assert property (
    (status_reg & mask_reg) == 2'h0 |=> !irq_reg)
    else $error("interrupt high with no unmasked status");
  read_answer_a: assert property (
    s_axi_arvalid && arready_reg |=> rvalid_reg && !arready_reg)
    else $error("read not answered one cycle after address");
  bresp_map_a: assert property (
    do_write && !addr_known(wr_addr_reg) |=> bresp_reg == DTEC_RESP_SLVERR)
    else $error("unmapped write not refused");

  both_irq_c: cover property (match[0] ##[1:300] match[1]);
  clear_race_c: cover property (match[0] && status_clear[0]);
endmodule

// [dtec_pulse_model.sv]
/*
  Far-side model: two event pulse sources and a square-wave load.
  Assumes it shares aclk with the block; pins change just after a rising edge.
*/
`timescale 1ns/100ps

module dtec_pulse_model (
  input wire logic aclk,
  input wire logic wave_two,
  output logic ev_one,
  output logic ev_two,
  output logic [7:0] toggles_two
);
  logic wave_two_q;

  initial begin
    ev_one = 1'b0;
    ev_two = 1'b0;
    toggles_two = 8'h00;
    wave_two_q = 1'b0;
  end

  // Load side counts level changes; an unknown level is not a change
  always @(posedge aclk) begin
    wave_two_q <= wave_two;
    if (wave_two != wave_two_q) begin
      toggles_two <= toggles_two + 8'h01;
    end
  end

  // Each level is held three cycles so the block sees every edge
  task automatic drive(input int ch, input logic v);
    @(posedge aclk);
    if (ch == 1) begin
      ev_one <= v;
    end else begin
      ev_two <= v;
    end
    repeat (2) @(posedge aclk);
  endtask

  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      drive(ch, 1'b1);
      drive(ch, 1'b0);
    end
  endtask
endmodule

// [testbench.sv]
/*
  Self-checking bench: AXI4-Lite register access, edge counting, compare
  match, square waves, interrupt and prescaled count periods.
  Assumes the design files and the pulse model are compiled first.
*/
`timescale 1ns/100ps
`include "dtec_defs.svh"

module testbench
  import dtec_pkg::*;
();
  localparam int CEIL = 60000;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ev_one, ev_two, wave_one, wave_two;
  logic irq_one, irq_two, irq;
  logic [7:0] awaddr, araddr, toggles_two;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  int mcnt [2] = '{0, 0};
  int mlast [2] = '{0, 0};
  int mgap [2] = '{0, 0};

  dtec_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chan_one_event_input(ev_one),
    .chan_two_event_input(ev_two), .chan_one_wave_output(wave_one),
    .chan_two_wave_output(wave_two), .chan_one_match_irq(irq_one),
    .chan_two_match_irq(irq_two), .irq(irq));

  dtec_pulse_model src (.aclk(aclk), .wave_two(wave_two), .ev_one(ev_one),
    .ev_two(ev_two), .toggles_two(toggles_two));

  initial aclk = 1'b0;
  always #10 aclk = ~aclk;

  // Match pulse monitor: count and spacing in cycles, per channel
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    for (int ch = 0; ch < 2; ch++) begin
      if ((ch == 0) ? irq_one === 1'b1 : irq_two === 1'b1) begin
        mgap[ch] <= cyc - mlast[ch];
        mlast[ch] <= cyc;
        mcnt[ch] <= mcnt[ch] + 1;
      end
    end
    if (cyc == CEIL) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ready is registered, so the level seen at the falling edge is what the next rise samples
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("write response", 32'(DTEC_RESP_OKAY), 32'(r));
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    axi_read(a, rd, rs);
    check(what, exp, rd);
  endtask

  task automatic gap_chk(input int ch, input int exp);
    int n0;
    n0 = mcnt[ch];
    while (mcnt[ch] < n0 + 2) @(negedge aclk);
    check("match interval", exp, mgap[ch]);
  endtask

  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a <= 32; a += 4) rd_chk("reset value", 8'(a), 32'h0);
    axi_read(8'h24, rd, rs);
    check("unmapped read", 32'(DTEC_RESP_SLVERR), 32'(rs));
    axi_write(8'h24, 32'hff, rs);
    check("unmapped write", 32'(DTEC_RESP_SLVERR), 32'(rs));
    // Lane zero strobe off: the write is dropped but still answered
    wstrb <= 4'h0;
    wr(`DTEC_ADDR_CMP_ONE, 32'hff);
    wstrb <= 4'h1;
    rd_chk("lane zero off", `DTEC_ADDR_CMP_ONE, 32'h0);
    $display("test registers done");
    // Channel one counts falling edges, channel two rising edges
    wr(`DTEC_ADDR_CLK_SEL, 32'h10);
    rd_chk("clock select", `DTEC_ADDR_CLK_SEL, 32'h10);
    wr(`DTEC_ADDR_CMP_ONE, 32'h3);
    wr(`DTEC_ADDR_CMP_TWO, 32'h5);
    src.drive(1, 1'b1);
    rd_chk("count one after rise", `DTEC_ADDR_CNT_ONE, 32'h0);
    src.drive(1, 1'b0);
    rd_chk("count one after fall", `DTEC_ADDR_CNT_ONE, 32'h1);
    src.pulse(1, 2);
    rd_chk("count one", `DTEC_ADDR_CNT_ONE, 32'h3);
    rd_chk("count two idle", `DTEC_ADDR_CNT_TWO, 32'h0);
    src.pulse(2, 2);
    rd_chk("count two", `DTEC_ADDR_CNT_TWO, 32'h2);
    wr(`DTEC_ADDR_OUT_CTRL, 32'h11);
    n = mcnt[0];
    src.pulse(1, 1);
    rd_chk("count one at match", `DTEC_ADDR_CNT_ONE, 32'h0);
    check("match pulses one", n + 1, mcnt[0]);
    check("wave one", 32'h1, wave_one);
    rd_chk("status", `DTEC_ADDR_STATUS, 32'h1);
    src.pulse(1, 1);
    rd_chk("count one restart", `DTEC_ADDR_CNT_ONE, 32'h1);
    src.pulse(2, 4);
    rd_chk("count two at match", `DTEC_ADDR_CNT_TWO, 32'h0);
    check("wave two", 32'h1, wave_two);
    check("wave two toggles", 32'h1, toggles_two);
    check("irq masked", 32'h0, irq);
    $display("test event counting done");
    wr(`DTEC_ADDR_MASK, 32'h2);
    @(negedge aclk);
    check("irq enabled", 32'h1, irq);
    wr(`DTEC_ADDR_STATUS, 32'h2);
    @(negedge aclk);
    check("irq cleared", 32'h0, irq);
    rd_chk("status after clear", `DTEC_ADDR_STATUS, 32'h1);
    $display("test interrupt done");
    wr(`DTEC_ADDR_OUT_CTRL, 32'h88);
    @(negedge aclk);
    check("wave one preset low", 32'h0, wave_one);
    // The load sees the new level one edge after it is launched
    @(negedge aclk);
    check("wave two toggles", 32'h2, toggles_two);
    wr(`DTEC_ADDR_OUT_CTRL, 32'h04);
    @(negedge aclk);
    check("wave one preset high", 32'h1, wave_one);
    rd_chk("level bits read", `DTEC_ADDR_OUT_CTRL, 32'h0);
    $display("test output preset done");
    // Compare of zero makes every count tick a match
    wr(`DTEC_ADDR_CMP_ONE, 32'h0);
    wr(`DTEC_ADDR_CMP_TWO, 32'h0);
    wr(`DTEC_ADDR_OSC_MODE, 32'h1);
    for (int c = 6; c <= 15; c++) begin
      for (int ch = 0; ch < 2; ch++) begin
        wr(`DTEC_ADDR_CLK_SEL, 32'(c << (4 * ch)));
        gap_chk(ch, (c == 15) ? 2048 : (1 << (c - 5)));
      end
    end
    wr(`DTEC_ADDR_OSC_MODE, 32'h0);
    wr(`DTEC_ADDR_CLK_SEL, 32'h06);
    gap_chk(0, 4);
    $display("test prescaler done");
    close_out();
  end
endmodule
